/* File: hw/fpim_consts.vh */
// Constants for the fieldbus process image map
`ifndef FPIM_CONSTS_VH
`define FPIM_CONSTS_VH
`define FPIM_IMAGE_WORDS 101
`define FPIM_USABLE_WORDS 100
`define FPIM_CTRL_POS 7'h00
`define FPIM_CTRL_ENABLE 16'h0001
`define FPIM_PARAM_COUNT 64
`define FPIM_MAP_UNMAPPED 2'h0
`define FPIM_MAP_WORD16 2'h1
`define FPIM_MAP_DWORD 2'h2
`define FPIM_MAP_HIGHONLY 2'h3
`define FPIM_IP_RESET 32'h00000000
`define FPIM_MASK_RESET 32'hffffff00
`define FPIM_GW_RESET 32'h00000000
`define FPIM_NAME_LEN_RESET 8'h00
`define FPIM_FIFO_DEPTH 16
`endif

/* File: hw/fpim_fifo.v */
// Parameterised valid/ready FIFO for the process image map
`timescale 1ns/1ns
`default_nettype none
module fpim_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire doWrite;
    wire doRead;
    assign inReady = (count != DEPTH);
    assign outValid = (count != 0);
    assign outData = mem[rdPtr];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    always @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
        if (!reset_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // fpim_fifo
`default_nettype wire

/* File: hw/fpim_process_image_map.v */
// Cyclic process image with translation tables for a fieldbus drive
//
// Overview of operation
// - Each cycle moves a fixed image of 101 sixteen-bit words each way.
// - Word 0 is reserved both ways and host input data is used only while input word 0 holds 1.
// - Unmapped positions are carried through but never touch any drive parameter.
// - Outputs are sent every cycle while an input word is applied only when it changed.
// - A 32-bit parameter may be mapped only at an odd position and even attempts are refused.
// - Output map picks parameters sent to the host, input map picks parameters written by it.
// - Messages are pure data whose layout is fixed at connection setup and exchanged periodically.
// - Network settings reset to empty name, address 0.0.0.0, mask 255.255.255.0, gateway 0.0.0.0.
`timescale 1ns/1ns
`default_nettype none
`include "fpim_consts.vh"
module fpim_process_image_map #(
    parameter PARAMS = `FPIM_PARAM_COUNT,
    parameter PW = 6,
    parameter FIFO_DEPTH = `FPIM_FIFO_DEPTH
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Mapping configuration, taken only while no connection is open
    input wire cfgWrite,
    input wire cfgOutDir,
    input wire [6:0] cfgPos,
    input wire [1:0] cfgKind,
    input wire [PW-1:0] cfgParam,
    output reg cfgRefused,
    output reg cfgAccepted,
    // Connection state from the fieldbus stack
    input wire connOpen,
    // Received image words, one per beat, position 0 first
    input wire rxValid,
    output wire rxReady,
    input wire [15:0] rxData,
    input wire rxFirst,
    // Transmitted image words
    input wire txStart,
    output reg txValid,
    input wire txReady,
    output reg [15:0] txData,
    output reg txFirst,
    // Drive parameter side
    output reg parWrite,
    output reg [PW-1:0] parWrIndex,
    output reg [31:0] parWrData,
    output reg [31:0] parWrMask,
    input wire [32*PARAMS-1:0] parValues,
    // Status
    output reg inputsEnabled,
    output reg fieldbusMappingFault,
    output reg [31:0] netIpAddr,
    output reg [31:0] netSubnet,
    output reg [31:0] netGateway,
    output reg [7:0] netNameLen
);
    // --------------------------------------------------------------
    // Translation tables and last-seen input words
    // --------------------------------------------------------------
    reg [1:0] outKind [0:`FPIM_USABLE_WORDS];
    reg [PW-1:0] outParam [0:`FPIM_USABLE_WORDS];
    reg [1:0] inKind [0:`FPIM_USABLE_WORDS];
    reg [PW-1:0] inParam [0:`FPIM_USABLE_WORDS];
    reg [15:0] lastIn [0:`FPIM_USABLE_WORDS];
    reg [`FPIM_USABLE_WORDS:0] lastValid;
    reg [6:0] txPos;
    reg [15:0] hiHold;
    reg hiFresh;
    integer i;

    localparam ST_IDLE = 2'b01;
    localparam ST_SEND = 2'b10;
    reg [1:0] txState;

    wire [16:0] fifoWord;
    wire [15:0] fifoData;
    wire fifoValid;
    wire fifoReady;
    wire [6:0] curPos;
    reg [6:0] fifoPos;
    wire [31:0] txNextPar;
    wire [31:0] txCurPar;

    function [31:0] param_of;
        input [32*PARAMS-1:0] vals;
        input [PW-1:0] idx;
        begin
            param_of = vals[idx*32 +: 32];
        end
    endfunction

    function pos_ok;
        input [6:0] pos;
        input [1:0] kind;
        begin
            pos_ok = (pos >= 7'h01) && (pos <= 7'h64) &&
                ((kind != `FPIM_MAP_DWORD) || (pos[0] && pos != 7'h64));
        end
    endfunction

    // --------------------------------------------------------------
    // Receive path buffered so up to 16 host image words are held while no connection is open
    // --------------------------------------------------------------
    fpim_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH), .AW(4)) rxFifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inValid(rxValid),
        .inReady(rxReady),
        .inData({rxFirst, rxData}),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoWord)
    );
    // The first-word mark travels with the data so a lost beat cannot shift every later position
    assign curPos = fifoWord[16] ? 7'h00 : fifoPos;
    assign fifoData = fifoWord[15:0];
    // Held while disconnected, which is the only back-pressure the host sees
    assign fifoReady = connOpen;
    assign txNextPar = param_of(parValues, outParam[txPos + 7'h01]);
    assign txCurPar = param_of(parValues, outParam[txPos]);

    // --------------------------------------------------------------
    // Configuration and input application
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            cfgRefused <= 1'b0;
            cfgAccepted <= 1'b0;
            fifoPos <= 7'h00;
            parWrite <= 1'b0;
            parWrIndex <= {PW{1'b0}};
            parWrData <= 32'h00000000;
            parWrMask <= 32'h00000000;
            inputsEnabled <= 1'b0;
            fieldbusMappingFault <= 1'b0;
            lastValid <= {(`FPIM_USABLE_WORDS+1){1'b0}};
            hiHold <= 16'h0000;
            hiFresh <= 1'b0;
            netIpAddr <= `FPIM_IP_RESET;
            netSubnet <= `FPIM_MASK_RESET;
            netGateway <= `FPIM_GW_RESET;
            netNameLen <= `FPIM_NAME_LEN_RESET;
            for (i = 0; i <= `FPIM_USABLE_WORDS; i = i + 1) begin
                outKind[i] <= `FPIM_MAP_UNMAPPED;
                inKind[i] <= `FPIM_MAP_UNMAPPED;
                outParam[i] <= {PW{1'b0}};
                inParam[i] <= {PW{1'b0}};
                lastIn[i] <= 16'h0000;
            end
        end else begin
            cfgRefused <= 1'b0;
            cfgAccepted <= 1'b0;
            parWrite <= 1'b0;
            // Layout frozen while connected so the meaning cannot shift mid-session
            if (cfgWrite) begin
                if (connOpen || !pos_ok(cfgPos, cfgKind) || cfgParam >= PARAMS) begin
                    cfgRefused <= 1'b1;
                    fieldbusMappingFault <= 1'b1;
                end else begin
                    cfgAccepted <= 1'b1;
                    if (cfgOutDir) begin
                        outKind[cfgPos] <= cfgKind;
                        outParam[cfgPos] <= cfgParam;
                    end else begin
                        inKind[cfgPos] <= cfgKind;
                        inParam[cfgPos] <= cfgParam;
                        lastValid[cfgPos] <= 1'b0;
                    end
                end
            end
            if (!connOpen) begin
                inputsEnabled <= 1'b0;
                fifoPos <= 7'h00;
            end else if (fifoValid) begin
                fifoPos <= (curPos == `FPIM_USABLE_WORDS) ? 7'h00 : curPos + 7'h01;
                if (curPos == `FPIM_CTRL_POS) begin
                    inputsEnabled <= (fifoData == `FPIM_CTRL_ENABLE);
                end else if (inputsEnabled && inKind[curPos] != `FPIM_MAP_UNMAPPED) begin
                    if (!lastValid[curPos] || lastIn[curPos] != fifoData) begin
                        lastValid[curPos] <= 1'b1;
                        lastIn[curPos] <= fifoData;
                        parWrite <= (inKind[curPos] != `FPIM_MAP_DWORD);
                        parWrIndex <= inParam[curPos];
                        case (inKind[curPos])
                            `FPIM_MAP_WORD16: begin
                                parWrData <= {16'h0000, fifoData};
                                parWrMask <= 32'h0000ffff;
                            end
                            `FPIM_MAP_HIGHONLY: begin
                                parWrData <= {fifoData, 16'h0000};
                                parWrMask <= 32'hffff0000;
                            end
                            default: begin
                                hiHold <= fifoData;
                                hiFresh <= 1'b1;
                            end
                        endcase
                    end else if (inKind[curPos] == `FPIM_MAP_DWORD) begin
                        hiFresh <= 1'b0;
                    end
                end else if (inputsEnabled && curPos[0] == 1'b0 &&
                             inKind[curPos - 7'h01] == `FPIM_MAP_DWORD) begin
                    // Low half of a 32-bit pair; whole pair written together, only when either half moved
                    if (hiFresh || !lastValid[curPos] || lastIn[curPos] != fifoData) begin
                        lastValid[curPos] <= 1'b1;
                        lastIn[curPos] <= fifoData;
                        parWrite <= 1'b1;
                        parWrIndex <= inParam[curPos - 7'h01];
                        parWrData <= {hiHold, fifoData};
                        parWrMask <= 32'hffffffff;
                    end
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Transmit path: full image every cycle
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            txState <= ST_IDLE;
            txPos <= 7'h00;
            txValid <= 1'b0;
            txData <= 16'h0000;
            txFirst <= 1'b0;
        end else begin
            case (txState)
                ST_IDLE: begin
                    if (txStart && connOpen) begin
                        txState <= ST_SEND;
                        txPos <= 7'h00;
                        txValid <= 1'b1;
                        txFirst <= 1'b1;
                        txData <= 16'h0000;
                    end
                end
                ST_SEND: begin
                    if (txReady) begin
                        txFirst <= 1'b0;
                        if (txPos == `FPIM_USABLE_WORDS) begin
                            txState <= ST_IDLE;
                            txValid <= 1'b0;
                        end else begin
                            txPos <= txPos + 7'h01;
                            case (outKind[txPos + 7'h01])
                                `FPIM_MAP_WORD16: txData <= txNextPar[15:0];
                                `FPIM_MAP_DWORD, `FPIM_MAP_HIGHONLY:
                                    txData <= txNextPar[31:16];
                                default: begin
                                    if (txPos[0] && outKind[txPos] == `FPIM_MAP_DWORD) begin
                                        txData <= txCurPar[15:0];
                                    end else begin
                                        txData <= 16'h0000;
                                    end
                                end
                            endcase
                        end
                    end
                end
                default: txState <= ST_IDLE;
            endcase
        end
    end
endmodule // fpim_process_image_map
`default_nettype wire

/* File: test/fpim_map_monitor.sv */
// Port-level checker for the process image map
`timescale 1ns/1ns
`default_nettype none
module fpim_map_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Configuration
    input wire logic cfgWrite,
    input wire logic [6:0] cfgPos,
    input wire logic [1:0] cfgKind,
    input wire logic connOpen,
    input wire logic cfgAccepted,
    input wire logic cfgRefused,
    input wire logic fieldbusMappingFault,
    // Transmit side
    input wire logic txStart,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic txFirst,
    input wire logic [15:0] txData,
    // Network defaults
    input wire logic [31:0] netIpAddr,
    input wire logic [31:0] netSubnet,
    input wire logic [31:0] netGateway,
    input wire logic [7:0] netNameLen
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [6:0] txCnt;
    // Counts accepted beats so a short or long frame shows at its end
    always @(posedge clk_sys) begin
        if (!reset_n)
            txCnt <= 7'h00;
        else if (txValid && txReady)
            txCnt <= txFirst ? 7'h01 : txCnt + 7'h01;
    end
    a_cfg_open_refused: assert property (cfgWrite && connOpen |=> cfgRefused && !cfgAccepted)
        else $error("config taken while connected");
    a_dword_even_refused: assert property (cfgWrite && cfgKind == 2'h2 && !cfgPos[0] |=> cfgRefused)
        else $error("double word at even position not refused");
    a_pos_range_refused: assert property (cfgWrite && (cfgPos == 7'h00 || cfgPos > 7'h64) |=> cfgRefused)
        else $error("position outside 1 to 100 not refused");
    a_cfg_answer_once: assert property (cfgWrite |=> cfgAccepted != cfgRefused)
        else $error("config answer missing or doubled");
    a_fault_follows: assert property (cfgRefused |-> ##[0:1] fieldbusMappingFault)
        else $error("refusal without mapping fault");
    a_fault_sticky: assert property (fieldbusMappingFault |=> fieldbusMappingFault)
        else $error("mapping fault cleared");
    a_tx_word0_zero: assert property (txValid && txFirst |-> txData == 16'h0000)
        else $error("reserved output word not zero");
    a_tx_hold_word: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txFirst))
        else $error("output word changed while stalled");
    a_tx_start_frame: assert property (txStart && connOpen && !txValid |=> txValid && txFirst)
        else $error("output frame did not start");
    a_tx_frame_len: assert property ($fell(txValid) |-> txCnt == 7'h65)
        else $error("output frame length wrong");
    a_net_defaults: assert property (
        netIpAddr == 32'h0 && netSubnet == 32'hffffff00 && netGateway == 32'h0 && netNameLen == 8'h00)
        else $error("network defaults wrong");
endmodule // fpim_map_monitor
bind fpim_process_image_map fpim_map_monitor mon (.clk_sys, .reset_n, .cfgWrite, .cfgPos, .cfgKind,
    .connOpen, .cfgAccepted, .cfgRefused, .fieldbusMappingFault, .txStart, .txValid, .txReady, .txFirst,
    .txData, .netIpAddr, .netSubnet, .netGateway, .netNameLen);
`default_nettype wire

/* File: test/fpim_host_model.sv */
// Host controller model: sends image frames, takes drive words with stalls
`timescale 1ns/1ns
`default_nettype none
module fpim_host_model (
    // Clock
    input wire logic clk_sys,
    // Image to the drive
    output logic rxValid = 1'b0,
    input wire logic rxReady,
    output logic [15:0] rxData = 16'h0000,
    output logic rxFirst = 1'b0,
    // Image from the drive
    input wire logic txValid,
    output logic txReady = 1'b0,
    input wire logic [15:0] txData,
    input wire logic txFirst
);
    logic [15:0] img [0:100];
    logic [16:0] txq [$];
    logic [7:0] st = 8'h5a;
    always @(posedge clk_sys) begin
        st <= {st[6:0], st[7] ^ st[5]};
        txReady <= st[0] | st[2];
        if (txValid && txReady)
            txq.push_back({txFirst, txData});
    end
    // Gives up after 9 refused edges, which is how a full buffer is found
    task automatic sendFrame(input int n, output int sent);
        int w;
        sent = 0;
        for (int k = 0; k < n; k++) begin
            rxValid <= 1'b1;
            rxData <= img[k];
            rxFirst <= (k == 0);
            w = 0;
            @(posedge clk_sys);
            while (!rxReady && w < 8) begin
                w++;
                @(posedge clk_sys);
            end
            if (!rxReady)
                break;
            sent++;
        end
        rxValid <= 1'b0;
        rxData <= ~rxData;
    endtask
endmodule // fpim_host_model
`default_nettype wire

/* File: test/fieldbus_process_image_map_tb.sv */
// Self-checking bench for the process image map
`timescale 1ns/1ns
`default_nettype none
module fieldbus_process_image_map_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, cfgOutDir = 1'b0, connOpen = 1'b0, txStart = 1'b0;
    logic [6:0] cfgPos = 7'h00;
    logic [1:0] cfgKind = 2'h0;
    logic [5:0] cfgParam = 6'h00;
    logic [2047:0] parValues = '0;
    logic cfgRefused, cfgAccepted, rxValid, rxReady, rxFirst, txValid, txReady, txFirst, parWrite;
    logic inputsEnabled, fieldbusMappingFault;
    logic [15:0] rxData, txData, e;
    logic [5:0] parWrIndex;
    logic [31:0] parWrData, parWrMask, netIpAddr, netSubnet, netGateway, pv;
    logic [7:0] netNameLen;
    logic [31:0] rs = 32'hc81a;
    logic [1:0] kin [0:101], kout [0:101];
    logic [5:0] pin [0:101], pout [0:101];
    logic [15:0] prev [0:101];
    logic seen [0:101];
    logic [69:0] expQ [$];
    int nFail = 0, comparisons = 0, sent;
    fpim_process_image_map dut (.clk_sys, .reset_n, .cfgWrite, .cfgOutDir, .cfgPos, .cfgKind, .cfgParam,
        .cfgRefused, .cfgAccepted, .connOpen, .rxValid, .rxReady, .rxData, .rxFirst, .txStart, .txValid,
        .txReady, .txData, .txFirst, .parWrite, .parWrIndex, .parWrData, .parWrMask, .parValues,
        .inputsEnabled, .fieldbusMappingFault, .netIpAddr, .netSubnet, .netGateway, .netNameLen);
    fpim_host_model host (.clk_sys, .rxValid, .rxReady, .rxData, .rxFirst, .txValid, .txReady, .txData, .txFirst);
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic void step();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
    endfunction
    task automatic chk(input string nm, input logic [69:0] x, input logic [69:0] g);
        comparisons++;
        if (g !== x) begin
            nFail++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cfg(input logic d, input logic [6:0] p, input logic [1:0] k, input logic [5:0] q, input logic r);
        cfgWrite <= 1'b1;
        cfgOutDir <= d;
        cfgPos <= p;
        cfgKind <= k;
        cfgParam <= q;
        @(posedge clk_sys);
        cfgWrite <= 1'b0;
        #1;
        chk("cfgRefused", r, cfgRefused);
        chk("cfgAccepted", !r, cfgAccepted);
        if (!r && d)
            {kout[p], pout[p]} = {k, q};
        if (!r && !d)
            {kin[p], pin[p]} = {k, q};
        @(posedge clk_sys);
    endtask
    // Expected writes follow position order; words only count while word 0 holds 1
    task frame;
        for (int p = 1; p <= 100; p++) begin
            if (host.img[0] == 16'h0001) begin
                if (kin[p] == 2'h1 && (!seen[p] || host.img[p] !== prev[p]))
                    expQ.push_back({pin[p], 16'h0000, host.img[p], 32'h0000ffff});
                if (kin[p] == 2'h2 && (!seen[p] || host.img[p] !== prev[p] || host.img[p+1] !== prev[p+1]))
                    expQ.push_back({pin[p], host.img[p], host.img[p+1], 32'hffffffff});
                if (kin[p] == 2'h3 && (!seen[p] || host.img[p] !== prev[p]))
                    expQ.push_back({pin[p], host.img[p], 16'h0000, 32'hffff0000});
                prev[p] = host.img[p];
                seen[p] = 1'b1;
            end
        end
        host.sendFrame(101, sent);
        chk("rxWords", 101, sent);
        repeat (10) @(posedge clk_sys);
        chk("pendingWrites", 0, expQ.size());
        chk("inputsEnabled", host.img[0] == 16'h0001, inputsEnabled);
    endtask
    always @(posedge clk_sys) begin
        if (reset_n && parWrite === 1'b1 && expQ.size() == 0)
            chk("parWrite", 70'h0, {parWrIndex, parWrData, parWrMask});
        else if (reset_n && parWrite === 1'b1)
            chk("parWrite", expQ.pop_front(), {parWrIndex, parWrData, parWrMask});
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        nFail++;
        close_out;
    end
    initial begin
        for (int i = 0; i < 102; i++)
            {kin[i], kout[i], seen[i]} = '0;
        for (int i = 0; i < 64; i++) begin
            step();
            parValues[32*i +: 32] = rs;
        end
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk("netSubnet", 32'hffffff00, netSubnet);
        cfg(1'b0, 7'h03, 2'h1, 6'h05, 1'b0);
        cfg(1'b0, 7'h05, 2'h2, 6'h07, 1'b0);
        cfg(1'b0, 7'h08, 2'h3, 6'h09, 1'b0);
        cfg(1'b0, 7'h04, 2'h2, 6'h01, 1'b1);
        cfg(1'b0, 7'h00, 2'h1, 6'h01, 1'b1);
        cfg(1'b0, 7'h65, 2'h1, 6'h01, 1'b1);
        cfg(1'b0, 7'h64, 2'h2, 6'h01, 1'b1);
        cfg(1'b1, 7'h01, 2'h1, 6'h02, 1'b0);
        cfg(1'b1, 7'h03, 2'h2, 6'h04, 1'b0);
        cfg(1'b1, 7'h06, 2'h3, 6'h09, 1'b0);
        cfg(1'b1, 7'h02, 2'h2, 6'h04, 1'b1);
        connOpen <= 1'b1;
        cfg(1'b1, 7'h09, 2'h1, 6'h03, 1'b1);
        chk("fieldbusMappingFault", 1, fieldbusMappingFault);
        $display("test config done");
        for (int f = 0; f < 3; f++) begin
            for (int i = 1; i <= 100 && f < 2; i++) begin
                step();
                host.img[i] = rs[15:0];
            end
            if (f == 2)
                {host.img[3], host.img[6]} = {~host.img[3], ~host.img[6]};
            host.img[0] = f ? 16'h0001 : 16'h0000;
            frame();
            $display("test frame %0d done", f);
        end
        txStart <= 1'b1;
        @(posedge clk_sys);
        txStart <= 1'b0;
        for (int w = 0; w < 800 && host.txq.size() < 101; w++)
            @(posedge clk_sys);
        for (int p = 0; p <= 100; p++) begin
            pv = parValues[32*pout[p] +: 32];
            e = kout[p] == 2'h1 ? pv[15:0] : kout[p] != 2'h0 ? pv[31:16] : 16'h0000;
            if (p > 0 && kout[p-1] == 2'h2)
                e = parValues[32*pout[p-1] +: 16];
            chk("txWord", {p == 0, e}, host.txq.size() ? host.txq.pop_front() : 17'h1ffff);
        end
        $display("test transmit done");
        connOpen <= 1'b0;
        host.sendFrame(20, sent);
        chk("fifoFill", 16, sent);
        connOpen <= 1'b1;
        repeat (30) @(posedge clk_sys);
        chk("rxReady", 1, rxReady);
        $display("test buffer done");
        close_out;
    end
endmodule // fieldbus_process_image_map_tb
`default_nettype wire
